// File: rtl/ltic_defs.svh
// Offsets, field positions, reset values and timing counts of the link test and I2C control bank
`ifndef LTIC_DEFS_SVH
`define LTIC_DEFS_SVH

`define LTIC_ADDR_SELF_TEST   8'h14
`define LTIC_ADDR_WATCHDOG    8'h16
`define LTIC_ADDR_I2C_CTRL    8'h17
`define LTIC_ADDR_SCL_HIGH    8'h18

`define LTIC_BIT_SELF_TEST_EN 0
`define LTIC_BIT_LINK_MODE    4
`define LTIC_BIT_WDOG_DIS     0
`define LTIC_BIT_FWD_ALL      7

`define LTIC_RST_SELF_TEST    8'h00
`define LTIC_RST_WATCHDOG     8'hfe
`define LTIC_RST_I2C_CTRL     8'h1e
`define LTIC_RST_SCL_HIGH     8'h7f

// Clock period and documented time units
`define LTIC_CLK_PERIOD_NS    10
`define LTIC_WDOG_STEP_MS     2
`define LTIC_HOLD_STEP_NS     40
`define LTIC_FILTER_STEP_NS   5
// Extra oscillator periods added to the SCL high count
`define LTIC_SCL_HIGH_EXTRA   5
// Cycles per watchdog step: 2 ms at 10 ns
`define LTIC_WDOG_STEP_CYC    ((`LTIC_WDOG_STEP_MS * 1000000) / `LTIC_CLK_PERIOD_NS)
// Cycles per hold step, rounded up
`define LTIC_HOLD_STEP_CYC    ((`LTIC_HOLD_STEP_NS + `LTIC_CLK_PERIOD_NS - 1) / `LTIC_CLK_PERIOD_NS)

`endif

// File: rtl/ltic_pkg.sv
// Types of the link test and I2C control bank
package ltic_pkg;

  typedef enum logic [1:0] {
    LTIC_CLK_PIXEL,
    LTIC_CLK_OSC_33,
    LTIC_CLK_OSC_100
  } ltic_test_clock_type;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic       remote;
    logic [7:0] addr;
    logic [7:0] wdata;
  } ltic_reg_req_type;

  typedef struct packed {
    logic       self_test_enable;
    logic [1:0] test_clock_select;
  } ltic_port_test_type;

  typedef enum logic [1:0] {
    LTIC_WD_IDLE,
    LTIC_WD_RUN,
    LTIC_WD_EXPIRED
  } ltic_wd_state_type;

endpackage : ltic_pkg

// File: rtl/ltic_sync_filter.sv
// Two-flop synchroniser with a programmable glitch filter and hold delay
`include "ltic_defs.svh"

module ltic_sync_filter (
  input  wire logic       clk,
  input  wire logic       arst_n,
  input  wire logic       pin_in,
  input  wire logic [3:0] filter_depth,
  input  wire logic [2:0] hold_steps,
  output logic            filt_out
);

  logic        meta_r;
  logic        sync_r;
  logic        stable_r;
  logic [4:0]  run_r;
  logic [27:0] hold_r;
  logic [4:0]  min_run;

  // ************************************************
  // Synchroniser
  // ************************************************
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      meta_r <= 1'b1;
      sync_r <= 1'b1;
    end else begin
      meta_r <= pin_in;
      sync_r <= meta_r;
    end
  end

  // ************************************************
  // Glitch filter
  // ************************************************
  // Depth in 5 ns units; a 10 ns clock resolves to whole cycles, rounded up
  assign min_run = 5'((({1'b0, filter_depth} * `LTIC_FILTER_STEP_NS) + `LTIC_CLK_PERIOD_NS - 1)
                   / `LTIC_CLK_PERIOD_NS);

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      stable_r <= 1'b1;
      run_r    <= 5'h00;
    end else if (sync_r == stable_r) begin
      run_r <= 5'h00;
    end else if (run_r >= min_run) begin
      stable_r <= sync_r;
      run_r    <= 5'h00;
    end else begin
      run_r <= run_r + 5'h01;
    end
  end

  // ************************************************
  // Hold delay line
  // ************************************************
  // Shift line long enough for 7 steps of 40 ns
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      hold_r <= 28'hfffffff;
    end else begin
      hold_r <= {hold_r[26:0], stable_r};
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      filt_out <= 1'b1;
    end else if (hold_steps == 3'h0) begin
      filt_out <= stable_r;
    end else begin
      filt_out <= hold_r[5'(hold_steps * `LTIC_HOLD_STEP_CYC - 1)];
    end
  end

endmodule // ltic_sync_filter

// File: rtl/ltic_scl_high_timer.sv
// Counts the minimum SCL high period of the local master
`include "ltic_defs.svh"

module ltic_scl_high_timer (
  input  wire logic       clk,
  input  wire logic       arst_n,
  input  wire logic       osc_tick,
  input  wire logic       start,
  input  wire logic [7:0] high_count,
  output logic            busy,
  output logic            done
);

  logic [8:0] cnt_r;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cnt_r <= 9'h000;
      done  <= 1'b0;
    end else begin
      done <= 1'b0;
      if (start) begin
        cnt_r <= 9'(high_count) + 9'(`LTIC_SCL_HIGH_EXTRA);
      end else if (osc_tick && cnt_r != 9'h000) begin
        cnt_r <= cnt_r - 9'h001;
        done  <= (cnt_r == 9'h001);
      end
    end
  end

  assign busy = (cnt_r != 9'h000);

endmodule // ltic_scl_high_timer

// File: rtl/ltic_regs.sv
// Link test and I2C control register bank with watchdog, forwarding and I2C timing
`include "ltic_defs.svh"

module ltic_regs (
  input  wire logic                         clk,
  input  wire logic                         arst_n,
  // Register access from local I2C target or the side channel
  input  wire ltic_pkg::ltic_reg_req_type   reg_req,
  output logic [7:0]                        reg_rdata,
  output logic                              reg_rvalid,
  // Port select held by the port select register
  input  wire logic                         second_port_select,
  input  wire logic                         split_mode,
  // Oscillator enable pulse, nominal period
  input  wire logic                         osc_tick,
  // Control channel transaction tracking
  input  wire logic                         chan_start,
  input  wire logic                         chan_done,
  output logic                              chan_abort,
  // Local I2C forwarding decision
  input  wire logic                         i2c_addr_valid,
  input  wire logic [6:0]                   i2c_addr,
  input  wire logic [6:0]                   own_target_addr,
  input  wire logic [6:0]                   remote_deser_addr,
  input  wire logic [6:0]                   remote_target_addr,
  input  wire logic                         i2c_on_second_port,
  output logic                              forward_access,
  // I2C pins
  input  wire logic                         scl_pin,
  input  wire logic                         sda_pin,
  output logic                              scl_filtered,
  output logic                              sda_filtered,
  // Local master SCL high timing
  input  wire logic                         scl_high_start,
  output logic                              scl_high_busy,
  output logic                              scl_high_done,
  // Per-port self-test controls, shared link mode enable and channel timeout disable
  output ltic_pkg::ltic_port_test_type      port_test_first,
  output ltic_pkg::ltic_port_test_type      port_test_second,
  output ltic_pkg::ltic_test_clock_type     active_clock_first,
  output ltic_pkg::ltic_test_clock_type     active_clock_second,
  output logic                              special_link_mode_enable,
  output logic                              channel_timeout_disable
);

  // ************************************************
  // Register state
  // ************************************************
  ltic_pkg::ltic_port_test_type test_first_r;
  ltic_pkg::ltic_port_test_type test_second_r;
  logic                         link_mode_r;
  logic [6:0]                   timeout_r;
  logic                         wdog_dis_r;
  logic                         fwd_all_first_r;
  logic                         fwd_all_second_r;
  logic [2:0]                   sda_hold_r;
  logic [3:0]                   filter_depth_r;
  logic [7:0]                   scl_high_r;

  logic wr_test;
  logic wr_wdog;
  logic wr_i2c;
  logic wr_scl;
  logic use_second;

  assign wr_test = reg_req.wr && reg_req.addr == `LTIC_ADDR_SELF_TEST;
  assign wr_wdog = reg_req.wr && reg_req.addr == `LTIC_ADDR_WATCHDOG;
  assign wr_i2c  = reg_req.wr && reg_req.addr == `LTIC_ADDR_I2C_CTRL;
  assign wr_scl  = reg_req.wr && reg_req.addr == `LTIC_ADDR_SCL_HIGH;

  // Outside splitter or 2:2 operation only the first self-test copy is used
  assign use_second = second_port_select && split_mode;

  // ************************************************
  // Self-test register
  // ************************************************
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      test_first_r  <= '0;
      test_second_r <= '0;
    end else if (wr_test) begin
      if (use_second) begin
        test_second_r.self_test_enable  <= reg_req.wdata[`LTIC_BIT_SELF_TEST_EN];
        test_second_r.test_clock_select <= reg_req.wdata[2:1];
      end else begin
        test_first_r.self_test_enable  <= reg_req.wdata[`LTIC_BIT_SELF_TEST_EN];
        test_first_r.test_clock_select <= reg_req.wdata[2:1];
      end
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      link_mode_r <= 1'(`LTIC_RST_SELF_TEST >> `LTIC_BIT_LINK_MODE);
    end else if (wr_test && !reg_req.remote) begin
      link_mode_r <= reg_req.wdata[`LTIC_BIT_LINK_MODE];
    end
  end

  function automatic ltic_pkg::ltic_test_clock_type clk_decode(input ltic_pkg::ltic_port_test_type t);
    if (!t.self_test_enable) begin
      clk_decode = ltic_pkg::LTIC_CLK_PIXEL;
    end else if (t.test_clock_select[1]) begin
      clk_decode = ltic_pkg::LTIC_CLK_OSC_100;
    end else if (t.test_clock_select[0]) begin
      clk_decode = ltic_pkg::LTIC_CLK_OSC_33;
    end else begin
      clk_decode = ltic_pkg::LTIC_CLK_PIXEL;
    end
  endfunction

  assign port_test_first          = test_first_r;
  assign port_test_second         = test_second_r;
  assign special_link_mode_enable = link_mode_r;

  // Registered so a clock mux select never glitches while a write lands
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      active_clock_first  <= ltic_pkg::LTIC_CLK_PIXEL;
      active_clock_second <= ltic_pkg::LTIC_CLK_PIXEL;
    end else begin
      active_clock_first  <= clk_decode(test_first_r);
      active_clock_second <= clk_decode(test_second_r);
    end
  end

  // ************************************************
  // Watchdog register
  // ************************************************
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      timeout_r  <= 7'(`LTIC_RST_WATCHDOG >> 1);
      wdog_dis_r <= 1'(`LTIC_RST_WATCHDOG);
    end else if (wr_wdog) begin
      timeout_r  <= reg_req.wdata[7:1];
      wdog_dis_r <= reg_req.wdata[`LTIC_BIT_WDOG_DIS];
    end
  end

  assign channel_timeout_disable = wdog_dis_r;

  // ************************************************
  // I2C control and SCL high registers
  // ************************************************
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      fwd_all_first_r  <= 1'(`LTIC_RST_I2C_CTRL >> `LTIC_BIT_FWD_ALL);
      fwd_all_second_r <= 1'(`LTIC_RST_I2C_CTRL >> `LTIC_BIT_FWD_ALL);
    end else if (wr_i2c) begin
      if (second_port_select) begin
        fwd_all_second_r <= reg_req.wdata[`LTIC_BIT_FWD_ALL];
      end else begin
        fwd_all_first_r <= reg_req.wdata[`LTIC_BIT_FWD_ALL];
      end
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      sda_hold_r     <= 3'(`LTIC_RST_I2C_CTRL >> 4);
      filter_depth_r <= 4'(`LTIC_RST_I2C_CTRL);
    end else if (wr_i2c) begin
      sda_hold_r     <= reg_req.wdata[6:4];
      filter_depth_r <= reg_req.wdata[3:0];
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      scl_high_r <= `LTIC_RST_SCL_HIGH;
    end else if (wr_scl) begin
      scl_high_r <= reg_req.wdata;
    end
  end

  // ************************************************
  // Read path
  // ************************************************
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      reg_rdata  <= 8'h00;
      reg_rvalid <= 1'b0;
    end else begin
      reg_rvalid <= reg_req.rd;
      if (reg_req.rd) begin
        case (reg_req.addr)
          `LTIC_ADDR_SELF_TEST: begin
            reg_rdata <= use_second ? {3'h0, link_mode_r, 1'b0, test_second_r.test_clock_select,
                                       test_second_r.self_test_enable}
                                    : {3'h0, link_mode_r, 1'b0, test_first_r.test_clock_select,
                                       test_first_r.self_test_enable};
          end
          `LTIC_ADDR_WATCHDOG: begin
            reg_rdata <= {timeout_r, wdog_dis_r};
          end
          `LTIC_ADDR_I2C_CTRL: begin
            reg_rdata <= {second_port_select ? fwd_all_second_r : fwd_all_first_r,
                          sda_hold_r, filter_depth_r};
          end
          `LTIC_ADDR_SCL_HIGH: begin
            reg_rdata <= scl_high_r;
          end
          default: begin
            reg_rdata <= 8'h00;
          end
        endcase
      end
    end
  end

  // ************************************************
  // Control channel watchdog
  // ************************************************
  // Step counter shared by all transactions; a full 7-bit count of 2 ms steps
  ltic_pkg::ltic_wd_state_type wd_state_r;
  logic [17:0]                 step_cnt_r;
  logic [6:0]                  steps_r;
  logic                        step_tick;

  assign step_tick = (step_cnt_r == 18'(`LTIC_WDOG_STEP_CYC - 1));

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      wd_state_r <= ltic_pkg::LTIC_WD_IDLE;
      step_cnt_r <= 18'h00000;
      steps_r    <= 7'h00;
      chan_abort <= 1'b0;
    end else begin
      chan_abort <= 1'b0;
      case (wd_state_r)
        ltic_pkg::LTIC_WD_IDLE: begin
          if (chan_start) begin
            wd_state_r <= ltic_pkg::LTIC_WD_RUN;
            step_cnt_r <= 18'h00000;
            steps_r    <= 7'h00;
          end
        end
        ltic_pkg::LTIC_WD_RUN: begin
          if (chan_done) begin
            wd_state_r <= ltic_pkg::LTIC_WD_IDLE;
          end else if (chan_start) begin
            step_cnt_r <= 18'h00000;
            steps_r    <= 7'h00;
          end else if (step_tick) begin
            step_cnt_r <= 18'h00000;
            steps_r    <= steps_r + 7'h01;
            // A zero timeout is never programmed, so expire on reaching it
            if (steps_r + 7'h01 >= timeout_r && !wdog_dis_r) begin
              wd_state_r <= ltic_pkg::LTIC_WD_EXPIRED;
            end
          end else begin
            step_cnt_r <= step_cnt_r + 18'h00001;
          end
        end
        ltic_pkg::LTIC_WD_EXPIRED: begin
          // A new transaction supersedes the stalled one, so it is not aborted
          if (chan_start) begin
            wd_state_r <= ltic_pkg::LTIC_WD_RUN;
            step_cnt_r <= 18'h00000;
            steps_r    <= 7'h00;
          end else begin
            // A disable written in the step that expires still suppresses the abort; one written while in expiry lands too late
            chan_abort <= !wdog_dis_r;
            wd_state_r <= ltic_pkg::LTIC_WD_IDLE;
          end
        end
        default: begin
          wd_state_r <= ltic_pkg::LTIC_WD_IDLE;
        end
      endcase
    end
  end

  // ************************************************
  // Forwarding decision
  // ************************************************
  logic fwd_all_sel;

  assign fwd_all_sel = i2c_on_second_port ? fwd_all_second_r : fwd_all_first_r;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      forward_access <= 1'b0;
    end else if (!i2c_addr_valid) begin
      forward_access <= 1'b0;
    end else if (fwd_all_sel) begin
      forward_access <= (i2c_addr != own_target_addr);
    end else begin
      forward_access <= (i2c_addr == remote_deser_addr) || (i2c_addr == remote_target_addr);
    end
  end

  // ************************************************
  // Pin filtering and master timing
  // ************************************************
  ltic_sync_filter u_scl_filter (
    .clk          (clk),
    .arst_n       (arst_n),
    .pin_in       (scl_pin),
    .filter_depth (filter_depth_r),
    .hold_steps   (3'h0),
    .filt_out     (scl_filtered)
  );

  ltic_sync_filter u_sda_filter (
    .clk          (clk),
    .arst_n       (arst_n),
    .pin_in       (sda_pin),
    .filter_depth (filter_depth_r),
    .hold_steps   (sda_hold_r),
    .filt_out     (sda_filtered)
  );

  ltic_scl_high_timer u_scl_high (
    .clk        (clk),
    .arst_n     (arst_n),
    .osc_tick   (osc_tick),
    .start      (scl_high_start),
    .high_count (scl_high_r),
    .busy       (scl_high_busy),
    .done       (scl_high_done)
  );

endmodule // ltic_regs

// File: verification/ltic_chan_peer.sv
// Behavioural far end of the control channel: opens a transaction and optionally completes it
module ltic_chan_peer (
  input  wire logic        clk,
  input  wire logic        go,
  input  wire logic        finish,
  input  wire logic [15:0] hold_cycles,
  output logic             chan_start,
  output logic             chan_done
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    chan_start = 1'b0;
    chan_done  = 1'b0;
  end

  // A stalled peer never answers, which is what the watchdog exists for
  always @(posedge clk) begin
    if (go) begin
      @(negedge clk);
      chan_start <= 1'b1;
      @(negedge clk);
      chan_start <= 1'b0;
      if (finish) begin
        repeat (hold_cycles) @(negedge clk);
        chan_done <= 1'b1;
        @(negedge clk);
        chan_done <= 1'b0;
      end
    end
  end
endmodule // ltic_chan_peer

// File: verification/ltic_regs_chk.sv
// Concurrent checks on the ports of the link test and I2C control bank
`include "ltic_defs.svh"

module ltic_regs_chk (
  input  wire logic                          clk,
  input  wire logic                          arst_n,
  input  wire ltic_pkg::ltic_reg_req_type    reg_req,
  input  wire logic                          reg_rvalid,
  input  wire logic                          chan_start,
  input  wire logic                          chan_abort,
  input  wire logic                          channel_timeout_disable,
  input  wire logic                          i2c_addr_valid,
  input  wire logic [6:0]                    i2c_addr,
  input  wire logic [6:0]                    own_target_addr,
  input  wire logic [6:0]                    remote_deser_addr,
  input  wire logic [6:0]                    remote_target_addr,
  input  wire logic                          forward_access,
  input  wire logic                          scl_high_start,
  input  wire logic                          scl_high_busy,
  input  wire ltic_pkg::ltic_port_test_type  port_test_first,
  input  wire ltic_pkg::ltic_test_clock_type active_clock_first,
  input  wire logic                          special_link_mode_enable
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);

  property p_rvalid;
    reg_rvalid == $past(reg_req.rd);
  endproperty
  a_rvalid: assert property (p_rvalid) else $error("read answer not a single cycle after the request");

  property p_remote_link;
    reg_req.wr && reg_req.remote && reg_req.addr == `LTIC_ADDR_SELF_TEST |=> $stable(special_link_mode_enable);
  endproperty
  a_remote_link: assert property (p_remote_link) else $error("remote write changed link mode bit");

  property p_local_link;
    reg_req.wr && !reg_req.remote && reg_req.addr == `LTIC_ADDR_SELF_TEST
      |=> special_link_mode_enable == $past(reg_req.wdata[`LTIC_BIT_LINK_MODE]);
  endproperty
  a_local_link: assert property (p_local_link) else $error("local write to link mode bit lost");

  property p_wdog_dis;
    reg_req.wr && reg_req.addr == `LTIC_ADDR_WATCHDOG |=> channel_timeout_disable == $past(reg_req.wdata[0]);
  endproperty
  a_wdog_dis: assert property (p_wdog_dis) else $error("watchdog disable bit not written");

  property p_no_abort_disabled;
    channel_timeout_disable && $past(channel_timeout_disable) |-> !chan_abort;
  endproperty
  a_no_abort_disabled: assert property (p_no_abort_disabled) else $error("abort while watchdog disabled");

  property p_early_abort;
    chan_start |=> !chan_abort [*8];
  endproperty
  a_early_abort: assert property (p_early_abort) else $error("abort right after transaction start");

  property p_fwd_quiet;
    !i2c_addr_valid |=> !forward_access;
  endproperty
  a_fwd_quiet: assert property (p_fwd_quiet) else $error("forward without a query");

  property p_fwd_own;
    i2c_addr_valid && i2c_addr == own_target_addr |=> !forward_access;
  endproperty
  a_fwd_own: assert property (p_fwd_own) else $error("own address forwarded");

  property p_fwd_remote;
    i2c_addr_valid && i2c_addr != own_target_addr
      && (i2c_addr == remote_deser_addr || i2c_addr == remote_target_addr) |=> forward_access;
  endproperty
  a_fwd_remote: assert property (p_fwd_remote) else $error("remote target not forwarded");

  property p_clock_map;
    $stable(port_test_first) |-> active_clock_first == (!port_test_first.self_test_enable ? ltic_pkg::LTIC_CLK_PIXEL :
      port_test_first.test_clock_select == 2'h0 ? ltic_pkg::LTIC_CLK_PIXEL :
      port_test_first.test_clock_select == 2'h1 ? ltic_pkg::LTIC_CLK_OSC_33 : ltic_pkg::LTIC_CLK_OSC_100);
  endproperty
  a_clock_map: assert property (p_clock_map) else $error("wrong test clock chosen");

  property p_scl_busy;
    scl_high_start |=> scl_high_busy [*4];
  endproperty
  a_scl_busy: assert property (p_scl_busy) else $error("high period ended too soon");

  c_read: cover property (reg_req.rd ##1 reg_rvalid);
  c_fwd: cover property (i2c_addr_valid ##1 forward_access);
  c_chan: cover property (chan_start);
endmodule // ltic_regs_chk

// File: verification/tb.sv
// Self-checking testbench of the link test and I2C control bank
`include "ltic_defs.svh"

module tb;
  timeunit 1ns;
  timeprecision 1ps;

  logic                          clk = 1'b0;
  logic                          arst_n = 1'b0;
  ltic_pkg::ltic_reg_req_type    req = '0;
  logic [7:0]                    rdata;
  logic                          rvalid;
  logic                          sel2 = 1'b0, split = 1'b0, osc_tick = 1'b0;
  logic                          go = 1'b0, finish = 1'b0;
  logic [15:0]                   hold_cycles = 16'h0032;
  logic                          chan_start, chan_done, chan_abort;
  logic                          qv = 1'b0, q2 = 1'b0, fwd;
  logic [6:0]                    qa = 7'h00;
  logic                          scl = 1'b1, sda = 1'b1, scl_f, sda_f;
  logic                          hs = 1'b0, hbusy, hdone;
  ltic_pkg::ltic_port_test_type  pt1, pt2;
  ltic_pkg::ltic_test_clock_type ac1, ac2;
  logic                          link_en, wd_dis;
  int                            mismatches = 0, n_compared = 0, cnt;

  always #5 clk = ~clk;
  // Oscillator tick every second cycle keeps tick and clock visibly distinct
  always @(negedge clk) osc_tick <= ~osc_tick;

  ltic_regs uut (.clk(clk), .arst_n(arst_n), .reg_req(req), .reg_rdata(rdata), .reg_rvalid(rvalid),
    .second_port_select(sel2), .split_mode(split), .osc_tick(osc_tick), .chan_start(chan_start),
    .chan_done(chan_done), .chan_abort(chan_abort), .i2c_addr_valid(qv), .i2c_addr(qa),
    .own_target_addr(7'h10), .remote_deser_addr(7'h20), .remote_target_addr(7'h30),
    .i2c_on_second_port(q2), .forward_access(fwd), .scl_pin(scl), .sda_pin(sda), .scl_filtered(scl_f),
    .sda_filtered(sda_f), .scl_high_start(hs), .scl_high_busy(hbusy), .scl_high_done(hdone),
    .port_test_first(pt1), .port_test_second(pt2), .active_clock_first(ac1), .active_clock_second(ac2),
    .special_link_mode_enable(link_en), .channel_timeout_disable(wd_dis));

  ltic_chan_peer peer (.clk(clk), .go(go), .finish(finish), .hold_cycles(hold_cycles),
    .chan_start(chan_start), .chan_done(chan_done));

  // ****************************************
  // Access tasks
  // ****************************************
  task automatic check(input string name, input logic [7:0] exp, input logic [7:0] got);
    n_compared++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic remote);
    @(negedge clk);
    req = '{wr: 1'b1, rd: 1'b0, remote: remote, addr: a, wdata: d};
    @(negedge clk);
    req.wr = 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(negedge clk);
    req.rd   = 1'b1;
    req.addr = a;
    @(negedge clk);
    req.rd = 1'b0;
    check("rvalid", 8'h01, {7'h00, rvalid});
    check("rdata", exp, rdata);
  endtask

  task automatic query(input logic [6:0] a, input logic second, input logic exp);
    @(negedge clk);
    qv = 1'b1;
    qa = a;
    q2 = second;
    @(negedge clk);
    qv = 1'b0;
    check("forward", {7'h00, exp}, {7'h00, fwd});
  endtask

  task automatic complete_run;
    if (mismatches == 0 && n_compared > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  initial begin
    #200us;
    mismatches++;
    complete_run();
  end

  // ****************************************
  // Scenarios
  // ****************************************
  initial begin
    repeat (6) @(negedge clk);
    arst_n = 1'b1;
    rd(`LTIC_ADDR_SELF_TEST, 8'h00);
    rd(`LTIC_ADDR_WATCHDOG, 8'hfe);
    rd(`LTIC_ADDR_I2C_CTRL, 8'h1e);
    rd(`LTIC_ADDR_SCL_HIGH, 8'h7f);
    rd(8'h15, 8'h00);
    wr(`LTIC_ADDR_SELF_TEST, 8'hff, 1'b0);
    rd(`LTIC_ADDR_SELF_TEST, 8'h17);
    wr(`LTIC_ADDR_SELF_TEST, 8'h00, 1'b1);
    rd(`LTIC_ADDR_SELF_TEST, 8'h10);
    check("link_en", 8'h01, {7'h00, link_en});
    for (int s = 0; s < 4; s++) begin
      wr(`LTIC_ADDR_SELF_TEST, {5'h00, s[1:0], 1'b1}, 1'b0);
      @(negedge clk);
      check("clock", (s == 0) ? 8'h00 : (s == 1) ? 8'h01 : 8'h02, {6'h00, ac1});
    end
    wr(`LTIC_ADDR_SELF_TEST, 8'h00, 1'b0);
    @(negedge clk);
    check("clock_off", 8'h00, {6'h00, ac1});
    split = 1'b1;
    sel2 = 1'b1;
    wr(`LTIC_ADDR_SELF_TEST, 8'h05, 1'b0);
    check("second_copy", 8'h06, {5'h00, pt2});
    check("first_copy", 8'h00, {5'h00, pt1});
    rd(`LTIC_ADDR_SELF_TEST, 8'h05);
    check("clock_second", 8'h02, {6'h00, ac2});
    sel2 = 1'b0;
    rd(`LTIC_ADDR_SELF_TEST, 8'h00);
    sel2 = 1'b1;
    wr(`LTIC_ADDR_I2C_CTRL, 8'h9e, 1'b0);
    rd(`LTIC_ADDR_I2C_CTRL, 8'h9e);
    sel2 = 1'b0;
    rd(`LTIC_ADDR_I2C_CTRL, 8'h1e);
    query(7'h20, 1'b0, 1'b1);
    query(7'h30, 1'b0, 1'b1);
    query(7'h40, 1'b0, 1'b0);
    query(7'h40, 1'b1, 1'b1);
    query(7'h10, 1'b1, 1'b0);
    // Shortest legal timeout; zero is never programmed
    wr(`LTIC_ADDR_WATCHDOG, 8'h02, 1'b0);
    rd(`LTIC_ADDR_WATCHDOG, 8'h02);
    finish = 1'b1;
    go = 1'b1;
    @(negedge clk);
    go = 1'b0;
    cnt = 0;
    repeat (300) @(negedge clk) cnt += chan_abort;
    check("abort_done", 8'h00, cnt[7:0]);
    wr(`LTIC_ADDR_WATCHDOG, 8'h03, 1'b0);
    check("wd_dis", 8'h01, {7'h00, wd_dis});
    finish = 1'b0;
    go = 1'b1;
    @(negedge clk);
    go = 1'b0;
    cnt = 0;
    repeat (300) @(negedge clk) cnt += chan_abort;
    check("abort_dis", 8'h00, cnt[7:0]);
    wr(`LTIC_ADDR_SCL_HIGH, 8'h03, 1'b0);
    hs = 1'b1;
    @(negedge clk);
    hs = 1'b0;
    cnt = 0;
    while (hdone !== 1'b1 && cnt < 100) @(negedge clk) cnt++;
    check("scl_high_min", 8'h01, {7'h00, cnt >= 15});
    check("scl_high_max", 8'h01, {7'h00, cnt <= 20});
    @(negedge clk);
    scl = 1'b0;
    sda = 1'b0;
    repeat (3) @(negedge clk);
    scl = 1'b1;
    sda = 1'b1;
    cnt = 0;
    repeat (20) @(negedge clk) cnt += (scl_f !== 1'b1) + (sda_f !== 1'b1);
    check("glitch", 8'h00, cnt[7:0]);
    scl = 1'b0;
    sda = 1'b0;
    repeat (40) @(negedge clk);
    check("scl_low", 8'h00, {7'h00, scl_f});
    check("sda_low", 8'h00, {7'h00, sda_f});
    complete_run();
  end
endmodule // tb

bind ltic_regs ltic_regs_chk chk (.clk(clk), .arst_n(arst_n), .reg_req(reg_req), .reg_rvalid(reg_rvalid),
  .chan_start(chan_start), .chan_abort(chan_abort), .channel_timeout_disable(channel_timeout_disable),
  .i2c_addr_valid(i2c_addr_valid), .i2c_addr(i2c_addr), .own_target_addr(own_target_addr),
  .remote_deser_addr(remote_deser_addr), .remote_target_addr(remote_target_addr),
  .forward_access(forward_access), .scl_high_start(scl_high_start), .scl_high_busy(scl_high_busy),
  .port_test_first(port_test_first), .active_clock_first(active_clock_first),
  .special_link_mode_enable(special_link_mode_enable));
